// ### design/odtc_pkg.sv
// Package of constants and types for the DRAM termination mode control block
// What this block does
// - Read or mode register read in progress forces termination off, pin ignored.
// - After the read burst, pin control returns only if termination is enabled.
// - Power-down bit zero stops pin-controlled termination during power down.
// - Power down entry turns termination off within the disable window.
// - Power down exit turns termination back on one cycle after the enable window ends.
// - After the enable window ends, the pin governs termination again.
// - Power-down bit set and value nonzero keeps pin control in power down.
// - Self refresh entry turns termination off within the disable window.
// - Self refresh exit re-enables termination one cycle after the enable window ends, or within it if the power-down bit is set.
// - Deep power down turns termination off within the disable window, stays off.
// - CA training keeps termination off and ignores the pin.
// - Write leveling: pin switches only strobe termination; data termination stays off.
// - Termination is on only with a nonzero value field and the pin high.
// - Read turn-off starts with the read command itself, ahead of the edge two cycles before read latency.
// - Read turn-on is timed from the edge at read latency plus half burst.
// - Without an override, termination follows the pin one cycle later, through an output flop.
package odtc_pkg;
  // APB register byte offsets
  localparam logic [7:0] ODTC_OFF_MODE = 8'h00;
  localparam logic [7:0] ODTC_OFF_CTRL = 8'h04;
  localparam logic [7:0] ODTC_OFF_STATUS = 8'h08;
  localparam logic [7:0] ODTC_OFF_TIMING = 8'h0C;
  // Mode register fields
  localparam int ODTC_VAL_LSB = 0;
  localparam int ODTC_PD_BIT = 2;
  localparam logic [7:0] ODTC_MODE_RST = 8'h00;
  // Control register fields
  localparam int ODTC_CTRL_CAT = 0;
  localparam int ODTC_CTRL_WLV = 1;
  // Timing register fields: read latency [4:0], burst length [9:5]
  localparam logic [4:0] ODTC_READ_LAT_RST = 5'h06;
  localparam logic [4:0] ODTC_BURST_LEN_RST = 5'h08;
  // Windows in ns, converted to 200 MHz cycles
  localparam int ODTC_CLK_PS = 5000;
  localparam int ODTC_DIS_WIN_NS = 12;
  localparam int ODTC_EN_WIN_NS = 12;
  localparam int ODTC_DIS_WIN_CYC = (ODTC_DIS_WIN_NS * 1000) / ODTC_CLK_PS;
  localparam int ODTC_EN_WIN_CYC = (ODTC_EN_WIN_NS * 1000) / ODTC_CLK_PS;
  localparam int ODTC_CW = 4;

  typedef enum logic [2:0] {
    ODTC_CMD_NONE, ODTC_CMD_READ, ODTC_CMD_MODE_RD, ODTC_CMD_PDE,
    ODTC_CMD_PDX, ODTC_CMD_SRE, ODTC_CMD_SRX, ODTC_CMD_DPD
  } odtc_cmd_t;

  typedef enum logic [2:0] {
    ODTC_ST_ACTIVE, ODTC_ST_PD_ENTER, ODTC_ST_PD, ODTC_ST_SR_ENTER,
    ODTC_ST_SR, ODTC_ST_EXIT, ODTC_ST_DPD
  } odtc_state_t;
endpackage

// ### design/odtc_read_if.sv
// Interface carrying read-window timing between top and read tracker
`timescale 1ns/1ps
interface odtc_read_if;
  logic start;
  logic [4:0] read_latency;
  logic [4:0] burst_length;
  logic busy;
  modport tracker (input start, input read_latency, input burst_length, output busy);
  modport ctrl (output start, output read_latency, output burst_length, input busy);
endinterface

// ### design/odtc_read_track.sv
// Tracks the read override window from command to last data beat
`timescale 1ns/1ps
module odtc_read_track
  import odtc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Read timing
  odtc_read_if.tracker rd
);
  logic [6:0] cnt_q;
  logic [6:0] end_at;

  // Back on at read latency plus half the burst
  assign end_at = {2'b00, rd.read_latency} + {3'b000, rd.burst_length[4:1]};

  // A new read restarts the window, so back-to-back reads extend it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (rd.start) begin
      cnt_q <= 7'h01;
    end else if (cnt_q != 7'h00 && cnt_q < end_at) begin
      cnt_q <= cnt_q + 7'h01;
    end else begin
      cnt_q <= 7'h00;
    end
  end

  // Off from the command itself, ahead of the edge two cycles before latency, through the final beat
  assign rd.busy = rd.start || cnt_q != 7'h00;
endmodule

// ### design/odtc_top.sv
// On-die termination gating for the DRAM with APB register access
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module odtc_top
  import odtc_pkg::*;
#(
  parameter int DISABLE_CYC = ODTC_DIS_WIN_CYC,
  parameter int ENABLE_CYC = ODTC_EN_WIN_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Registered command and termination pin
  input wire logic [2:0] cmd,
  input wire logic cmd_valid,
  input wire logic odt_pin,
  // Termination enables
  output logic dq_term_on,
  output logic dqs_term_on
);
  logic [7:0] mode_q;
  logic [1:0] ctrl_q;
  logic [9:0] timing_q;
  odtc_state_t state_q;
  logic [ODTC_CW-1:0] win_q;
  logic [31:0] rdata_d;
  logic hit;
  logic acc;
  logic val_nz;
  logic pd_keep;
  logic gate_ok;
  logic pin_term;
  odtc_cmd_t cmd_e;

  odtc_read_if rdi ();

  assign acc = psel && penable;
  assign cmd_e = odtc_cmd_t'(cmd);
  assign val_nz = mode_q[ODTC_VAL_LSB+1:ODTC_VAL_LSB] != 2'b00;
  assign pd_keep = mode_q[ODTC_PD_BIT] && val_nz;
  assign rdi.start = cmd_valid && (cmd_e == ODTC_CMD_READ || cmd_e == ODTC_CMD_MODE_RD);
  assign rdi.read_latency = timing_q[4:0];
  assign rdi.burst_length = timing_q[9:5];

  odtc_read_track u_rd (
    .pclk(pclk),
    .presetn(presetn),
    .rd(rdi)
  );

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= ODTC_MODE_RST;
      ctrl_q <= 2'b00;
      timing_q <= {ODTC_BURST_LEN_RST, ODTC_READ_LAT_RST};
    end else if (acc && pwrite) begin
      unique case (paddr)
        ODTC_OFF_MODE: mode_q <= pwdata[7:0];
        ODTC_OFF_CTRL: ctrl_q <= pwdata[1:0];
        ODTC_OFF_TIMING: timing_q <= pwdata[9:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    hit = 1'b1;
    rdata_d = 32'h00000000;
    unique case (paddr)
      ODTC_OFF_MODE: rdata_d = {24'h000000, mode_q};
      ODTC_OFF_CTRL: rdata_d = {30'h00000000, ctrl_q};
      ODTC_OFF_STATUS: rdata_d = {25'h0000000, rdi.busy, state_q, gate_ok, dqs_term_on, dq_term_on};
      ODTC_OFF_TIMING: rdata_d = {22'h000000, timing_q};
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait slave: answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h00000000;
    end
  end

  // Power state; the window counter models the disable and enable windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ODTC_ST_ACTIVE;
      win_q <= '0;
    end else begin
      if (win_q != '0) begin
        win_q <= win_q - 1'b1;
      end
      unique case (state_q)
        ODTC_ST_ACTIVE: begin
          if (cmd_valid && cmd_e == ODTC_CMD_PDE) begin
            state_q <= ODTC_ST_PD_ENTER;
            win_q <= ODTC_CW'(DISABLE_CYC);
          end else if (cmd_valid && cmd_e == ODTC_CMD_SRE) begin
            state_q <= ODTC_ST_SR_ENTER;
            win_q <= ODTC_CW'(DISABLE_CYC);
          end else if (cmd_valid && cmd_e == ODTC_CMD_DPD) begin
            state_q <= ODTC_ST_DPD;
          end
        end
        ODTC_ST_PD_ENTER: if (win_q <= 1) state_q <= ODTC_ST_PD;
        ODTC_ST_SR_ENTER: if (win_q <= 1) state_q <= ODTC_ST_SR;
        ODTC_ST_PD: begin
          if (cmd_valid && cmd_e == ODTC_CMD_PDX) begin
            state_q <= ODTC_ST_EXIT;
            win_q <= ODTC_CW'(ENABLE_CYC);
          end
        end
        ODTC_ST_SR: begin
          if (cmd_valid && cmd_e == ODTC_CMD_SRX) begin
            state_q <= ODTC_ST_EXIT;
            win_q <= ODTC_CW'(ENABLE_CYC);
          end
        end
        ODTC_ST_EXIT: if (win_q <= 1) state_q <= ODTC_ST_ACTIVE;
        // Left only by reset, as the controller re-initialises the part
        ODTC_ST_DPD: state_q <= ODTC_ST_DPD;
        default: state_q <= ODTC_ST_ACTIVE;
      endcase
    end
  end

  // State gate: which states let the pin act at all
  always_comb begin
    unique case (state_q)
      ODTC_ST_ACTIVE: gate_ok = 1'b1;
      ODTC_ST_PD_ENTER, ODTC_ST_PD, ODTC_ST_EXIT: gate_ok = pd_keep;
      ODTC_ST_SR_ENTER, ODTC_ST_SR: gate_ok = 1'b0;
      ODTC_ST_DPD: gate_ok = 1'b0;
      default: gate_ok = 1'b0;
    endcase
  end

  // Registered so every output comes from a flop; the cycle of lag stands in for the analog delay
  assign pin_term = val_nz && odt_pin && gate_ok && !rdi.busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_term_on <= 1'b0;
      dqs_term_on <= 1'b0;
    end else if (ctrl_q[ODTC_CTRL_CAT]) begin
      dq_term_on <= 1'b0;
      dqs_term_on <= 1'b0;
    end else if (ctrl_q[ODTC_CTRL_WLV]) begin
      dq_term_on <= 1'b0;
      dqs_term_on <= pin_term;
    end else begin
      dq_term_on <= pin_term;
      dqs_term_on <= pin_term;
    end
  end
endmodule

// ### sim/odtc_checker.sv
// Assertion checker for the termination gating block
`timescale 1ns/1ps
module odtc_checker
  import odtc_pkg::*;
#(parameter int DISABLE_CYC = 2, parameter int ENABLE_CYC = 2) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB writes
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Command, pin and termination
  input wire logic [2:0] cmd,
  input wire logic cmd_valid,
  input wire logic odt_pin,
  input wire logic dq_term_on,
  input wire logic dqs_term_on
);
  // Shadow copies of mode and control, since the checker cannot see the registers
  logic [2:0] mode_q;
  logic [1:0] ctrl_q;
  wire wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 3'h0;
      ctrl_q <= 2'h0;
    end else if (wr && paddr == ODTC_OFF_MODE) begin
      mode_q <= pwdata[2:0];
    end else if (wr && paddr == ODTC_OFF_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end
  // Exit window plus the registered output stage
  localparam int EXIT_LIM = ENABLE_CYC + 2;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_read_off: assert property (cmd_valid && cmd inside {ODTC_CMD_READ, ODTC_CMD_MODE_RD} |=> !dq_term_on [*8])
    else $error("read left termination on");
  a_read_back: assert property (cmd_valid && cmd == ODTC_CMD_READ && mode_q[1:0] != 2'h0 && ctrl_q == 2'h0
    ##1 (odt_pin && !cmd_valid) [*8] ##1 (odt_pin && !cmd_valid) [*3] |=> dq_term_on) else $error("no return");
  a_pin_off: assert property (!odt_pin || mode_q[1:0] == 2'h0 |=> !dq_term_on && !dqs_term_on)
    else $error("termination on without pin or value");
  a_pd_off: assert property (cmd_valid && cmd == ODTC_CMD_PDE && !mode_q[2] |-> ##2 !dq_term_on [*2])
    else $error("power down kept termination");
  a_sr_off: assert property (cmd_valid && cmd == ODTC_CMD_SRE |-> ##2 (!dq_term_on && !dqs_term_on) [*3])
    else $error("self refresh kept termination");
  a_deep_off: assert property (cmd_valid && cmd == ODTC_CMD_DPD |-> ##2 !dq_term_on [*8])
    else $error("deep power down kept termination");
  a_wlv_dq: assert property (ctrl_q == 2'h2 |=> !dq_term_on) else $error("data termination in leveling");
  a_cat_off: assert property (ctrl_q[0] |=> !dq_term_on && !dqs_term_on) else $error("termination in training");
  a_exit_on: assert property (cmd_valid && cmd inside {ODTC_CMD_PDX, ODTC_CMD_SRX} && mode_q[1:0] != 2'h0
    && ctrl_q == 2'h0 && odt_pin |-> ##[1:EXIT_LIM] (dq_term_on || !odt_pin || cmd_valid))
    else $error("exit left termination off");
  c_read: cover property (cmd_valid && cmd == ODTC_CMD_READ && dq_term_on);
  c_wlv: cover property (ctrl_q == 2'h2 && dqs_term_on);
  c_pd_keep: cover property (cmd_valid && cmd == ODTC_CMD_PDE && mode_q[2]);
endmodule
bind odtc_top odtc_checker #(.DISABLE_CYC(DISABLE_CYC), .ENABLE_CYC(ENABLE_CYC)) odtc_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .cmd(cmd), .cmd_valid(cmd_valid), .odt_pin(odt_pin), .dq_term_on(dq_term_on),
  .dqs_term_on(dqs_term_on));

// ### sim/odtc_ctrl_model.sv
// Memory controller model driving commands and the termination pin
`timescale 1ns/1ps
module odtc_ctrl_model
  import odtc_pkg::*;
(
  // Clock, command and pin
  input wire logic pclk,
  output logic [2:0] cmd = 3'h0,
  output logic cmd_valid = 1'b0,
  output logic odt_pin = 1'b0
);
  // After deep power down only a full power-up may follow, so commands stop
  logic dead = 1'b0;
  task automatic issue(input odtc_cmd_t c, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    if (!dead) begin
      cmd <= c;
      cmd_valid <= 1'b1;
    end
    dead = dead || c == ODTC_CMD_DPD;
    @(posedge pclk);
    cmd <= ~c;
    cmd_valid <= 1'b0;
  endtask
  // Callers keep the pin high throughout write leveling
  task automatic pin(input logic v);
    @(posedge pclk);
    odt_pin <= v;
  endtask
endmodule

// ### sim/tb_odtc_top.sv
// Self-checking testbench for the termination gating block
`timescale 1ns/1ps
module tb_odtc_top
  import odtc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] cmd;
  logic cmd_valid, odt_pin, dq_term_on, dqs_term_on;
  int fail_count = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] PD_MODE [3] = '{32'h1, 32'h5, 32'h5};
  localparam odtc_cmd_t GO_IN [3] = '{ODTC_CMD_PDE, ODTC_CMD_PDE, ODTC_CMD_SRE};
  localparam odtc_cmd_t GO_OUT [3] = '{ODTC_CMD_PDX, ODTC_CMD_PDX, ODTC_CMD_SRX};
  localparam logic [1:0] CT [3] = '{2'h2, 2'h1, 2'h3};
  always #2.5 pclk = ~pclk;
  odtc_top #(.DISABLE_CYC(2), .ENABLE_CYC(2)) odtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .cmd_valid(cmd_valid), .odt_pin(odt_pin), .dq_term_on(dq_term_on),
    .dqs_term_on(dqs_term_on));
  odtc_ctrl_model odtc_ctrl_model_inst (.pclk(pclk), .cmd(cmd), .cmd_valid(cmd_valid), .odt_pin(odt_pin));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Samples 1 ns after the edge so the registered outputs have settled
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic summarize();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ODTC_OFF_TIMING, 32'h0);
    chk("timing", 32'h106, rd);
    apb(1'b1, 8'h10, 32'hFF);
    chk("unmapped", 32'h1, err);
    $display("test registers done");
    odtc_ctrl_model_inst.pin(1'b1);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, ODTC_OFF_MODE, 32'(v));
      wt(2);
      chk("value", {v != 0, v != 0}, {dqs_term_on, dq_term_on});
    end
    odtc_ctrl_model_inst.pin(1'b0);
    wt(2);
    chk("pin_low", 32'h0, {dqs_term_on, dq_term_on});
    odtc_ctrl_model_inst.pin(1'b1);
    $display("test value and pin done");
    for (int i = 1; i < 3; i++) begin
      odtc_ctrl_model_inst.issue(odtc_cmd_t'(i), 0);
      wt(1);
      chk("read_off", 32'h0, dq_term_on);
      wt(9);
      chk("read_last", 32'h0, dq_term_on);
      wt(1);
      chk("read_back", 32'h1, dq_term_on);
    end
    $display("test reads done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ODTC_OFF_MODE, PD_MODE[i]);
      odtc_ctrl_model_inst.issue(GO_IN[i], i * 3);
      wt(4);
      chk("enter", {31'h0, i == 1}, dq_term_on);
      odtc_ctrl_model_inst.issue(GO_OUT[i], 0);
      wt(5);
      chk("exit", 32'h1, dq_term_on);
    end
    $display("test power states done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ODTC_OFF_CTRL, {30'h0, CT[i]});
      wt(2);
      chk("mode_ctrl", {i == 0, 1'b0}, {dqs_term_on, dq_term_on});
    end
    apb(1'b1, ODTC_OFF_CTRL, 32'h0);
    odtc_ctrl_model_inst.issue(ODTC_CMD_DPD, 0);
    wt(20);
    chk("deep", 32'h0, {dqs_term_on, dq_term_on});
    apb(1'b0, ODTC_OFF_STATUS, 32'h0);
    chk("state", 32'h6, rd[5:3]);
    // Deep power down is left only through a fresh reset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ODTC_OFF_STATUS, 32'h0);
    chk("after_reset", 32'h4, rd);
    $display("test modes and deep power down done");
    summarize();
  end
endmodule
